// [hw/noise_shaped_pwm_dac.sv]
// Purpose: apb programmed noise shaped pwm converter front end
// Assumes: ref_clk_i is the rc oscillator, 10 MHz, synchronous reset
// Notes:   amplifier and filter are analog and outside this block
//
// How it works
// - a 16-bit code is built from low and high byte registers.
// - both bytes reach the converter together only on a high byte write.
// - bits 7:6 pick shaper order: 00 none, 01 first, 1x second.
// - bits 5:3 set pwm resolution from 4 up to 11 bits.
// - bit 1 enables the converter, bit 2 enables the amplifier.
// - bit 0 runs the modulator at full or half clock rate.
// - aux bit 0 inverts the pwm output to active low.
// - system reset clears the converter registers to zero, except the active order, which resets to none.
// - shaper splits the code into m-bit codes averaging to the input.
// - order zero uses the top m bits directly as duty.
// - width is four plus the code; period spans 2**m modulator ticks.
// - first order uses adjacent codes; second order saturates at ends.
`timescale 1ns/100ps
module noise_shaped_pwm_dac (
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      psel_i,
	input  wire logic                      penable_i,
	input  wire logic                      pwrite_i,
	input  wire logic [dac_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]               pwdata_i,
	input  wire logic [3:0]                pstrb_i,
	output logic      [31:0]               prdata_o,
	output logic                           pready_o,
	output logic                           pslverr_o,
	output logic                           pwm_o,
	output logic                           amp_enable_o,
	output logic                           amp_wide_band_o
);
	import dac_pkg::*;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [7:0]  code_low_byte_q;
	logic [7:0]  code_high_byte_q;
	logic [7:0]  cfg_main_q;
	logic [7:0]  cfg_aux_q;
	logic [15:0] conv_code_q;       // code handed to the converter
	logic        code_new_q;        // transfer waiting for period start
	logic [15:0] act_code_q;        // code latched at period start
	logic [2:0]  act_width_q;
	shape_order_t act_order_q;
	shape_order_t order_sel;
	logic [17:0] err1_q;            // first integrator, signed
	logic [17:0] err2_q;            // first error one period back, signed
	logic [11:0] duty_q;
	logic        half_q;
	logic        tick;
	logic        run;
	logic        start;
	logic        pulse;
	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic [3:0]  sh;
	logic [11:0] full;
	logic signed [19:0] tgt;
	logic signed [19:0] lsb;
	logic signed [19:0] quant;
	logic signed [19:0] e1_new;
	logic signed [19:0] e2_new;
	logic signed [19:0] dv;
	logic signed [19:0] cand;

	// ------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------
	// zero wait: pready rises in the access cycle itself
	assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
	assign rd_acc = psel_i && penable_i && !pwrite_i && pready_o;
	assign mapped = (paddr_i == OFS_CODE_LOW) || (paddr_i == OFS_CODE_HIGH)
		|| (paddr_i == OFS_CONFIG_MAIN) || (paddr_i == OFS_CONFIG_AUX)
		|| (paddr_i == OFS_STATUS);

	// ready from a flop: high in the access phase, low otherwise
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !mapped;
		end
	end

	// register writes, low byte lane only; unmapped writes are dropped
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			code_low_byte_q  <= RST_BYTE;
			code_high_byte_q <= RST_BYTE;
			cfg_main_q       <= RST_BYTE;
			cfg_aux_q        <= RST_BYTE;
		end else if (wr_acc && pstrb_i[0]) begin
			unique case (paddr_i)
				OFS_CODE_LOW:    code_low_byte_q  <= pwdata_i[7:0];
				OFS_CODE_HIGH:   code_high_byte_q <= pwdata_i[7:0];
				OFS_CONFIG_MAIN: cfg_main_q       <= pwdata_i[7:0];
				OFS_CONFIG_AUX:  cfg_aux_q        <= pwdata_i[7:0];
				default: ;
			endcase
		end
	end

	// high byte write copies both bytes; software orders low first
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			conv_code_q <= '0;
			code_new_q  <= 1'b0;
		end else if (wr_acc && pstrb_i[0] && paddr_i == OFS_CODE_HIGH) begin
			conv_code_q <= {pwdata_i[7:0], code_low_byte_q};
			code_new_q  <= 1'b1;
		end else if (start) begin
			code_new_q  <= 1'b0;
		end
	end

	// read data; status shows active code and pending transfer
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			prdata_o <= '0;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			unique case (paddr_i)
				OFS_CODE_LOW:    prdata_o <= {24'h0, code_low_byte_q};
				OFS_CODE_HIGH:   prdata_o <= {24'h0, code_high_byte_q};
				OFS_CONFIG_MAIN: prdata_o <= {24'h0, cfg_main_q};
				OFS_CONFIG_AUX:  prdata_o <= {24'h0, cfg_aux_q};
				OFS_STATUS:      prdata_o <= {15'h0, code_new_q, act_code_q};
				default:         prdata_o <= '0;
			endcase
		end else if (rd_acc) begin
			prdata_o <= '0;
		end
	end

	// ------------------------------------------------------------------
	// modulator clock and counter
	// ------------------------------------------------------------------
	assign run = cfg_main_q[EN_CONV_BIT];

	// half rate by a toggle; no gated clock, just a tick enable
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !run) begin
			half_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
		end
	end
	assign tick = cfg_main_q[CLK_SEL_BIT] ? half_q : 1'b1;

	pwm_counter u_counter (
		.ref_clk_i      (ref_clk_i),
		.rst_i          (rst_i),
		.run_i          (run),
		.tick_i         (tick),
		.width_code_i   (act_width_q),
		.duty_i         (duty_q),
		.period_start_o (start),
		.pulse_o        (pulse)
	);

	// ------------------------------------------------------------------
	// settings latch at period start
	// ------------------------------------------------------------------
	always_comb begin
		unique case (cfg_main_q[ORDER_HI:ORDER_LO])
			2'b00:   order_sel = SHAPE_NONE;
			2'b01:   order_sel = SHAPE_FIRST;
			default: order_sel = SHAPE_SECOND;
		endcase
	end

	// taking everything at once avoids a truncated pulse
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !run) begin
			act_code_q  <= '0;
			act_width_q <= '0;
			act_order_q <= SHAPE_NONE;
		end else if (start) begin
			act_code_q  <= conv_code_q;
			act_width_q <= cfg_main_q[WIDTH_HI:WIDTH_LO];
			act_order_q <= order_sel;
		end
	end

	// ------------------------------------------------------------------
	// noise shaper
	// ------------------------------------------------------------------
	// target in units of 2**-16 full scale; one pwm step is 2**(16-m)
	assign sh   = 4'(12 - 32'(act_width_q));
	assign full = 12'(12'd1 << (4'(PWM_MIN_W) + 4'(act_width_q)));
	assign tgt  = 20'(act_code_q);
	assign lsb  = 20'(20'd1 << sh);

	// error feedback: order 1 adds e1, order 2 adds 2*e1 - e2
	always_comb begin
		dv = tgt;
		unique case (act_order_q)
			SHAPE_NONE:   dv = tgt;
			SHAPE_FIRST:  dv = tgt + $signed(20'(signed'(err1_q)));
			SHAPE_SECOND: dv = tgt + ($signed(20'(signed'(err1_q))) <<< 1)
				- $signed(20'(signed'(err2_q)));
		endcase
		// order zero truncates, shaped orders round to nearest step
		if (act_order_q == SHAPE_NONE) begin
			cand = dv >>> sh;
		end else begin
			cand = (dv + (lsb >>> 1)) >>> sh;
		end
		// saturate at zero and full scale; m-bit code max is 2**m - 1
		if (cand < 0) begin
			quant = '0;
		end else if (cand > $signed(20'(full) - 20'sd1)) begin
			quant = 20'(full) - 20'sd1;
		end else begin
			quant = cand;
		end
		e1_new = dv - (quant <<< sh);
		// bound the error so a saturated code cannot wind it up
		if (e1_new > (lsb >>> 1)) begin
			e1_new = lsb >>> 1;
		end else if (e1_new < -(lsb >>> 1)) begin
			e1_new = -(lsb >>> 1);
		end
		e2_new = $signed(20'(signed'(err1_q)));
	end

	// one shaper step per pwm period
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !run) begin
			err1_q <= '0;
			err2_q <= '0;
			duty_q <= '0;
		end else if (start) begin
			duty_q <= 12'(quant);
			if (act_order_q == SHAPE_NONE) begin
				err1_q <= '0;
				err2_q <= '0;
			end else begin
				err1_q <= 18'(e1_new);
				err2_q <= act_order_q == SHAPE_SECOND ? 18'(e2_new) : '0;
			end
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pwm_o           <= 1'b0;
			amp_enable_o    <= 1'b0;
			amp_wide_band_o <= 1'b0;
		end else begin
			pwm_o           <= (pulse && run) ^ cfg_aux_q[POL_BIT];
			amp_enable_o    <= cfg_main_q[EN_AMP_BIT];
			amp_wide_band_o <= cfg_aux_q[WIDE_BIT];
		end
	end
endmodule

// [inc/dac_pkg.sv]
// Purpose: shared constants for the noise shaped pwm converter
// Assumes: apb register access, 32-bit data, one aligned word per register
// Notes:   register offsets are byte addresses
package dac_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [11:0] OFS_CODE_LOW    = 12'h000;
	localparam logic [11:0] OFS_CODE_HIGH   = 12'h004;
	localparam logic [11:0] OFS_CONFIG_MAIN = 12'h008;
	localparam logic [11:0] OFS_CONFIG_AUX  = 12'h00c;
	localparam logic [11:0] OFS_STATUS      = 12'h010;
	localparam int ADDR_W = 12;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int ORDER_HI    = 7;
	localparam int ORDER_LO    = 6;
	localparam int WIDTH_HI    = 5;
	localparam int WIDTH_LO    = 3;
	localparam int EN_AMP_BIT  = 2;
	localparam int EN_CONV_BIT = 1;
	localparam int CLK_SEL_BIT = 0;
	localparam int POL_BIT     = 0;
	localparam int WIDE_BIT    = 1;

	// ------------------------------------------------------------------
	// reset values and sizes
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam int         CODE_W    = 16;
	localparam int         PWM_MIN_W = 4;
	localparam int         PWM_MAX_W = 11;

	// shaper order as decoded from the order field
	typedef enum logic [2:0] {
		SHAPE_NONE   = 3'b001,
		SHAPE_FIRST  = 3'b010,
		SHAPE_SECOND = 3'b100
	} shape_order_t;

endpackage

// [hw/pwm_counter.sv]
// Purpose: pwm period counter and comparator
// Assumes: tick_i paces the modulator clock
// Notes:   period is 2**width ticks, width 4..11
`timescale 1ns/100ps
module pwm_counter (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        run_i,
	input  wire logic        tick_i,
	input  wire logic [2:0]  width_code_i,
	input  wire logic [11:0] duty_i,
	output logic             period_start_o,
	output logic             pulse_o
);
	import dac_pkg::*;

	logic [10:0] cnt_q;
	logic [10:0] last;

	// ------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------
	// last count of the period is 2**m - 1, m = 4 + code
	assign last = 11'((12'd1 << (4'(PWM_MIN_W) + 4'(width_code_i))) - 12'd1);

	// wraps at the end of period; held at zero while stopped
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= '0;
		end else if (tick_i) begin
			cnt_q <= (cnt_q >= last) ? 11'd0 : cnt_q + 11'd1;
		end
	end

	// period start marks the tick that begins a fresh period
	assign period_start_o = run_i && tick_i && (cnt_q == 11'd0);
	// duty from the shaper saturates at 2**m - 1, never 2**m; compared at 12 bits
	assign pulse_o = run_i && ({1'b0, cnt_q} < duty_i);
endmodule

// [testbench/dac_monitor.sv]
// Purpose: port checks for the pwm converter
// Assumes: zero wait apb, registered outputs
// Notes:   enable and polarity shadowed from writes
`timescale 1ns/100ps
module dac_monitor (
	input wire logic                        ref_clk_i,
	input wire logic                        rst_i,
	input wire logic                        psel_i,
	input wire logic                        penable_i,
	input wire logic                        pwrite_i,
	input wire logic [dac_pkg::ADDR_W-1:0]  paddr_i,
	input wire logic [31:0]                 pwdata_i,
	input wire logic [3:0]                  pstrb_i,
	input wire logic [31:0]                 prdata_o,
	input wire logic                        pready_o,
	input wire logic                        pslverr_o,
	input wire logic                        pwm_o,
	input wire logic                        amp_enable_o,
	input wire logic                        amp_wide_band_o
);
	import dac_pkg::*;
	logic en_q;
	logic pol_q;
	wire logic wr = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
	wire logic wr_main = wr & (paddr_i == OFS_CONFIG_MAIN);
	wire logic wr_aux = wr & (paddr_i == OFS_CONFIG_AUX);
	// ----
	// shadow bits, taken at the same edge as the design
	// ----
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
			pol_q <= 1'b0;
		end else begin
			if (wr_main) en_q <= pwdata_i[EN_CONV_BIT];
			if (wr_aux) pol_q <= pwdata_i[POL_BIT];
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	// three cycles give the registered output time to settle
	sequence idle_s;
		(!en_q && $stable(pol_q))[*3];
	endsequence
	chk_pready_setup: assert property (setup_s |=> pready_o)
		else $error("pready late");
	chk_pready_once: assert property (pready_o |=> !pready_o)
		else $error("pready held");
	chk_pready_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("pready outside access");
	chk_unmapped_err: assert property
		((setup_s and (paddr_i > OFS_STATUS)) |=> pslverr_o)
		else $error("no error on unmapped");
	chk_unmapped_zero: assert property
		(pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	chk_amp_follow: assert property (wr_main |-> ##2
		amp_enable_o == $past(pwdata_i[EN_AMP_BIT], 2))
		else $error("amp enable wrong");
	chk_wide_follow: assert property (wr_aux |-> ##2
		amp_wide_band_o == $past(pwdata_i[WIDE_BIT], 2))
		else $error("wide band wrong");
	chk_idle_level: assert property (idle_s |-> pwm_o == pol_q)
		else $error("idle level wrong");
endmodule
bind noise_shaped_pwm_dac dac_monitor mon (.ref_clk_i, .rst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
	.pready_o, .pslverr_o, .pwm_o, .amp_enable_o, .amp_wide_band_o);

// [testbench/amp_filter_model.sv]
// Purpose: amplifier and filter load on the pwm line
// Assumes: filter level modelled as a count of high cycles
// Notes:   analog settling is not modelled
`timescale 1ns/100ps
module amp_filter_model (
	input  wire logic ref_clk_i,
	input  wire logic clear_i,
	input  wire logic pwm_i,
	input  wire logic amp_on_i,
	output int        level_o
);
	// integrate only while the amplifier is powered
	always_ff @(posedge ref_clk_i) begin
		if (clear_i) begin
			level_o <= 0;
		end else if (amp_on_i && pwm_i === 1'b1) begin
			level_o <= level_o + 1;
		end
	end
endmodule

// [testbench/testbench.sv]
// Purpose: self checking bench for the pwm converter
// Assumes: 10 MHz clock, apb master by tasks
// Notes:   duty measured as high cycles over whole periods
`timescale 1ns/100ps
module testbench;
	import dac_pkg::*;
	typedef struct {logic [7:0] m, a; logic [15:0] c; int np, hi;} row_t;
	logic ref_clk_i, rst_i = 1'b1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd_v;
	logic [3:0]  pstrb_i = 4'hf;
	logic pready_o, pslverr_o, pwm_o, amp_enable_o, amp_wide_band_o;
	logic er_v, clear_q = 1'b1;
	int level, num_errors = 0, checks_done = 0, p, prev = 0, got;
	// order, width, enables, clock, polarity, code, periods, high cycles
	row_t rows[8] = '{'{8'h06, 8'h00, 16'h5000, 4, 20},
		'{8'h06, 8'h03, 16'h5000, 4, 44}, '{8'h02, 8'h00, 16'h5000, 4, 0},
		'{8'h3f, 8'h00, 16'hffff, 1, 4094}, '{8'h66, 8'h00, 16'h5480, 4, 338},
		'{8'ha6, 8'h00, 16'h5480, 8, 676}, '{8'he6, 8'h00, 16'h5480, 8, 676},
		'{8'h26, 8'h00, 16'h12ff, 2, 36}};
	logic [11:0] offs[4] = '{OFS_CODE_LOW, OFS_CODE_HIGH, OFS_CONFIG_MAIN,
		OFS_CONFIG_AUX};
	noise_shaped_pwm_dac uut (.ref_clk_i, .rst_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
		.pslverr_o, .pwm_o, .amp_enable_o, .amp_wide_band_o);
	amp_filter_model filt (.ref_clk_i, .clear_i(clear_q), .pwm_i(pwm_o),
		.amp_on_i(amp_enable_o), .level_o(level));
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		if (n >= 16) chk(0, 1);
		rd_v = prdata_o;
		er_v = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
	endtask
	// count filter level over n clocks after a clear
	task automatic measure(input int n);
		clear_q <= 1'b1;
		@(posedge ref_clk_i);
		clear_q <= 1'b0;
		repeat (n) @(posedge ref_clk_i);
		// one more edge: level still holds the n samples before it
		@(posedge ref_clk_i);
		got = level;
	endtask
	task automatic settle;
		repeat (prev + 3 * p) @(posedge ref_clk_i);
		prev = p;
	endtask
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		num_errors++;
		finish_test();
	end
	// ----
	// main sequence
	// ----
	initial begin
		do_reset();
		foreach (rows[i]) begin
			wr(OFS_CONFIG_MAIN, rows[i].m);
			wr(OFS_CONFIG_AUX, rows[i].a);
			wr(OFS_CODE_LOW, rows[i].c[7:0]);
			wr(OFS_CODE_HIGH, rows[i].c[15:8]);
			p = (1 << (4 + rows[i].m[5:3])) * (rows[i].m[0] + 1);
			settle();
			measure(rows[i].np * p);
			chk(got, rows[i].hi);
			chk(amp_enable_o, rows[i].m[2]);
			chk(amp_wide_band_o, rows[i].a[1]);
		end
		// second reset in mid run, then defaults
		do_reset();
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 0);
			chk(rd_v, 0);
		end
		chk({pwm_o, amp_enable_o, amp_wide_band_o}, 0);
		apb(1'b0, 12'h020, 0);
		chk({er_v, rd_v[30:0]}, 32'h80000000);
		// a write without lane 0 must leave the register alone
		pstrb_i <= 4'he;
		wr(OFS_CONFIG_AUX, 8'h03);
		pstrb_i <= 4'hf;
		apb(1'b0, OFS_CONFIG_AUX, 0);
		chk(rd_v, 0);
		wr(OFS_CONFIG_MAIN, 8'h26);
		wr(OFS_CODE_LOW, 8'hff);
		wr(OFS_CODE_HIGH, 8'h12);
		p = 256;
		settle();
		apb(1'b0, OFS_STATUS, 0);
		chk(rd_v, 32'h12ff);
		wr(OFS_CODE_LOW, 8'h34);
		settle();
		apb(1'b0, OFS_STATUS, 0);
		chk(rd_v, 32'h12ff);
		wr(OFS_CODE_HIGH, 8'h80);
		settle();
		apb(1'b0, OFS_STATUS, 0);
		chk(rd_v, 32'h8034);
		// every width code at half scale
		// exact half scale so every width splits evenly
		wr(OFS_CODE_LOW, 8'h00);
		wr(OFS_CODE_HIGH, 8'h80);
		for (int w = 0; w < 8; w++) begin
			wr(OFS_CONFIG_MAIN, {2'b00, w[2:0], 3'b110});
			p = 1 << (4 + w);
			settle();
			measure(p);
			chk(got, p / 2);
		end
		wr(OFS_CONFIG_MAIN, 8'h04);
		wr(OFS_CONFIG_AUX, 8'h01);
		measure(64);
		chk(got, 64);
		finish_test();
	end
endmodule
